// *** testbench/art_timer_properties.sv ***
// art_timer_properties.sv: port checks of bus, control bits and irq.
// assumes it is bound into art_timer and sees only its ports.
`include "art_timer_map.vh"

module art_timer_properties (
  input wire        clk_sys,
  input wire        rst,
  input wire [5:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        irq
);
  logic       ie_q;
  logic [7:0] ctl_q;
  logic [1:0] seen_q;
  wire        rd_ok  = avs_read && !avs_waitrequest;
  wire        wr_ok  = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire        rd_ctl = rd_ok && avs_address == `ART_OFS_CTRL;
  wire        wr_ctl = wr_ok && avs_address == `ART_OFS_CTRL;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ------------------------------
  // shadow of software writes and of ctrl flags read back
  // ------------------------------
  // a flag read as set must stay set until software writes ctrl again
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ie_q   <= 1'h0;
      ctl_q  <= 8'h00;
      seen_q <= 2'h0;
    end else begin
      if (wr_ok && avs_address == `ART_OFS_IRQ_EN) ie_q <= avs_writedata[`ART_IE_TIMER];
      if (wr_ctl) ctl_q <= avs_writedata[7:0];
      seen_q <= wr_ctl ? 2'h0 : seen_q | (rd_ctl ? avs_readdata[7:6] : 2'h0);
    end
  end

  // ------------------------------
  // assertions and covers
  // ------------------------------
  property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("request not answered");
  property p_wait_pulse; $fell(avs_waitrequest) |=> $rose(avs_waitrequest); endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
  property p_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_upper; rd_ok |-> avs_readdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_unmapped; rd_ok && avs_address > `ART_OFS_MASK |-> avs_readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctl_back; rd_ctl |-> (avs_readdata[7:0] & 8'h3D) == (ctl_q & 8'h3D); endproperty
  a_ctl_back: assert property (p_ctl_back) else $error("ctrl bits differ");
  property p_rsv; rd_ctl |-> avs_readdata[1] == 1'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved ctrl bit set");
  property p_sticky; rd_ctl |-> (avs_readdata[7:6] & seen_q) == seen_q; endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");
  property p_irq_en; !ie_q && !$past(ie_q) |-> !irq; endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
  c_irq: cover property ($rose(irq));
  c_flag: cover property (rd_ctl && avs_readdata[7]);
  c_unmapped: cover property (rd_ok && avs_address > `ART_OFS_MASK);
endmodule

bind art_timer art_timer_properties u_art_props (
  .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

// *** testbench/art_timer_tb.sv ***
// art_timer_tb.sv: self-checking bench for art_timer over avalon-mm.
// assumes the register map header; the bench makes ext_osc itself.
`include "art_timer_map.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module art_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'h0;
  logic        rst = 1'h1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_osc = 1'h0;
  logic        irq;
  logic        osc_on = 1'h0;
  logic [7:0]  v;
  logic [7:0]  r;
  int          err_count = 0;
  int          n_compared = 0;
  int          seed = 32'hA7115E55;
  int          oc = 0;
  int          cap[$];

  art_timer dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_osc(ext_osc), .irq(irq));

  always #10 clk_sys = ~clk_sys;

  // osc toggles every 5 clocks, so one osc/8 period is 80 clocks
  always @(posedge clk_sys) begin
    oc <= (oc == 4) ? 0 : oc + 1;
    if (osc_on && oc == 4) ext_osc <= ~ext_osc;
  end

  // ------------------------------
  // bus and check tasks
  // ------------------------------
  // request held until waitrequest is sampled low; read data taken there
  task automatic xfer(input logic wr, input logic [5:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address    <= ad;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= 4'h1;
    avs_write      <= wr;
    avs_read       <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'h0 && ++n < 20);
    if (n == 20) err_count++;
    r = avs_readdata[7:0];
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    xfer(1'h1, ad, d);
  endtask

  task automatic ck(input logic [5:0] ad, input logic [7:0] e, input string nm);
    xfer(1'h0, ad, 8'h00);
    `CHK(nm, e, r)
  endtask

  // irq lags its cause by a cycle, so give it a few edges
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk_sys);
    `CHK("irq", e, irq)
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // the run needs about 1200 clocks; a hang is cut off well after that
  initial begin
    #600000;
    err_count++;
    print_verdict();
  end

  // ------------------------------
  // scenarios
  // ------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    for (int a = 0; a < 10; a++) ck(6'(a * 4), 8'h00, "reset word");
    v = $random(seed);
    wr(`ART_OFS_RLD_LO, v);
    wr(6'h24, 8'h5A);
    ck(`ART_OFS_RLD_LO, v, "reload_low");
    ck(6'h24, 8'h00, "unmapped");
    $display("test registers done");
    // 16-bit rollover from FFF0 takes a random high reload
    v = $random(seed);
    wr(`ART_OFS_CLK_CTRL, 8'h10);
    wr(`ART_OFS_IRQ_EN, 8'h20);
    wr(`ART_OFS_RLD_LO, 8'h00);
    wr(`ART_OFS_RLD_HI, v);
    wr(`ART_OFS_CNT_LO, 8'hF0);
    wr(`ART_OFS_CNT_HI, 8'hFF);
    wr(`ART_OFS_CTRL, 8'h04);
    repeat (60) @(posedge clk_sys);
    ck(`ART_OFS_CTRL, 8'hC4, "16-bit flags");
    irq_is(1'h1);
    wr(`ART_OFS_CTRL, 8'h00);
    ck(`ART_OFS_CNT_HI, v, "count_high");
    wr(`ART_OFS_MASK, 8'h01);
    irq_is(1'h1);
    ck(`ART_OFS_STATUS, 8'h03, "status");
    irq_is(1'h0);
    ck(`ART_OFS_STATUS, 8'h00, "status cleared");
    $display("test 16-bit done");
    // low byte rollover alone; irq only once the low enable is set
    wr(`ART_OFS_CNT_LO, 8'hF8);
    wr(`ART_OFS_CNT_HI, 8'h00);
    wr(`ART_OFS_CTRL, 8'h04);
    repeat (30) @(posedge clk_sys);
    ck(`ART_OFS_CTRL, 8'h44, "low flag");
    irq_is(1'h0);
    wr(`ART_OFS_CTRL, 8'h64);
    irq_is(1'h1);
    wr(`ART_OFS_CTRL, 8'h00);
    ck(`ART_OFS_STATUS, 8'h02, "low status");
    $display("test low byte done");
    // split: low runs with run_high clear, then high overflows alone
    v = $random(seed) & 8'h7F;
    wr(`ART_OFS_CLK_CTRL, 8'h30);
    wr(`ART_OFS_RLD_LO, v);
    wr(`ART_OFS_RLD_HI, 8'h00);
    wr(`ART_OFS_CNT_LO, 8'hF0);
    wr(`ART_OFS_CNT_HI, 8'hF0);
    wr(`ART_OFS_CTRL, 8'h08);
    repeat (30) @(posedge clk_sys);
    ck(`ART_OFS_CTRL, 8'h48, "split low flag");
    ck(`ART_OFS_CNT_HI, 8'hF0, "high held");
    irq_is(1'h0);
    wr(`ART_OFS_CTRL, 8'h0C);
    repeat (30) @(posedge clk_sys);
    ck(`ART_OFS_CTRL, 8'h8C, "split high flag");
    irq_is(1'h1);
    wr(`ART_OFS_CTRL, 8'h00);
    xfer(1'h0, `ART_OFS_CNT_LO, 8'h00);
    `CHK("low reloaded", 1'h1, r >= v && r < v + 8'h60)
    ck(`ART_OFS_STATUS, 8'h03, "split status");
    $display("test split done");
    // system_clock/12 then osc/8 counting clocks, within one tick of phase
    wr(`ART_OFS_CLK_CTRL, 8'h00);
    wr(`ART_OFS_CNT_LO, 8'h00);
    wr(`ART_OFS_CNT_HI, 8'h00);
    wr(`ART_OFS_CTRL, 8'h04);
    repeat (240) @(posedge clk_sys);
    wr(`ART_OFS_CTRL, 8'h00);
    xfer(1'h0, `ART_OFS_CNT_LO, 8'h00);
    `CHK("div12", 1'h1, r inside {[8'h13:8'h15]})
    osc_on <= 1'h1;
    wr(`ART_OFS_CNT_LO, 8'h00);
    wr(`ART_OFS_CTRL, 8'h05);
    repeat (400) @(posedge clk_sys);
    wr(`ART_OFS_CTRL, 8'h00);
    xfer(1'h0, `ART_OFS_CNT_LO, 8'h00);
    `CHK("osc div8", 1'h1, r inside {[8'h04:8'h06]})
    $display("test clocks done");
    // capture kept in 16-bit mode on a fast count clock
    // capture at system_clock: two captures one osc/8 period apart
    wr(`ART_OFS_CLK_CTRL, 8'h10);
    wr(`ART_OFS_CTRL, 8'h10);
    repeat (2) begin
      r = 8'h00;
      for (int n = 0; n < 60 && !r[7]; n++) xfer(1'h0, `ART_OFS_CTRL, 8'h00);
      xfer(1'h0, `ART_OFS_RLD_LO, 8'h00);
      v = r;
      xfer(1'h0, `ART_OFS_RLD_HI, 8'h00);
      cap.push_back({r, v});
      wr(`ART_OFS_CTRL, 8'h10);
    end
    `CHK("capture gap", 16'h0050, 16'(cap[1] - cap[0]))
    $display("test capture done");
    print_verdict();
  end
endmodule

// *** verilog/art_timer.v ***
// art_timer.v: 16-bit auto-reload timer built from two 8-bit halves,
// with split mode, external-oscillator capture and an avalon-mm slave.
// assumes ext_osc is a slow free-running oscillator, well below clk_sys/2.

`include "art_timer_map.vh"

module art_timer (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        ext_osc,
  output reg         irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg [7:0] ctrl_q;
  reg [7:0] ctrl_d;
  reg [7:0] count_low_q;
  reg [7:0] count_low_d;
  reg [7:0] count_high_q;
  reg [7:0] count_high_d;
  reg [7:0] reload_low_q;
  reg [7:0] reload_low_d;
  reg [7:0] reload_high_q;
  reg [7:0] reload_high_d;
  reg [7:0] clk_ctrl_q;
  reg [7:0] irq_en_q;
  reg [2:0] status_q;
  reg [2:0] status_d;
  reg [2:0] mask_q;
  reg [3:0] div12_q;
  reg       tick12_q;
  reg [2:0] osc_sync_q;
  reg [1:0] div8_cnt_q;
  reg       div8_q;
  reg       div8_old_q;
  wire do_wr;
  wire do_rd;
  wire tick8;
  wire capt_ev;
  wire lo_tick;
  wire hi_tick;
  wire capt_mode;
  wire split;
  wire run_high;
  wire low_irq_enable;
  reg ovf_lo_ev;
  reg ovf_hi_ev;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // clock select
  // picks the count enable for one half from its select and the ext bit
  function sel_tick;
    input sys_sel;
    input xclk;
    input t12;
    input t8;
    begin
      sel_tick = sys_sel || (xclk ? t8 : t12);
    end
  endfunction

  // write decode; strobe and address are arguments so always @* sees them
  function hit;
    input [5:0] ofs;
    input [5:0] adr;
    input       we;
    begin
      hit = we && (adr == ofs);
    end
  endfunction

  // ----------------------------------------------------------------------
  // bus slave: one wait cycle, then the answer
  // ----------------------------------------------------------------------
  assign do_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign do_rd = avs_read && !avs_waitrequest;

  // waitrequest drops for exactly one cycle per request
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // read data is presented alongside the low waitrequest
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      case (avs_address)
        `ART_OFS_CTRL:     avs_readdata <= {24'h000000, ctrl_q};
        `ART_OFS_CNT_LO:   avs_readdata <= {24'h000000, count_low_q};
        `ART_OFS_CNT_HI:   avs_readdata <= {24'h000000, count_high_q};
        `ART_OFS_RLD_LO:   avs_readdata <= {24'h000000, reload_low_q};
        `ART_OFS_RLD_HI:   avs_readdata <= {24'h000000, reload_high_q};
        `ART_OFS_CLK_CTRL: avs_readdata <= {24'h000000, clk_ctrl_q};
        `ART_OFS_IRQ_EN:   avs_readdata <= {24'h000000, irq_en_q};
        `ART_OFS_STATUS:   avs_readdata <= {29'h00000000, status_q};
        `ART_OFS_MASK:     avs_readdata <= {29'h00000000, mask_q};
        default:           avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // counting clocks
  // ----------------------------------------------------------------------
  // divide by 12
  // one enable pulse every twelfth clock, no derived clock net
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div12_q  <= 4'h0;
      tick12_q <= 1'b0;
    end else begin
      tick12_q <= (div12_q == `ART_DIV_SYS - 4'h1);
      div12_q  <= (div12_q == `ART_DIV_SYS - 4'h1) ? 4'h0 : div12_q + 4'h1;
    end
  end

  // sync and divide by 8
  // stage 0 feeds only stage 1; edges are found between stages 1 and 2
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_sync_q <= 3'h0;
      div8_cnt_q <= 2'h0;
      div8_q     <= 1'b0;
      div8_old_q <= 1'b0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], ext_osc};
      div8_old_q <= div8_q;
      if (osc_sync_q[1] && !osc_sync_q[2]) begin
        div8_cnt_q <= div8_cnt_q + 2'h1;
        if (div8_cnt_q == `ART_DIV_EXT_HALF) begin
          div8_q <= !div8_q;
        end
      end
    end
  end

  // capture edge
  // the /8 clock counts on its rising edge and captures on its falling one
  assign tick8   = div8_q && !div8_old_q;
  assign capt_ev = capt_mode && !div8_q && div8_old_q;

  assign split          = ctrl_q[`ART_CTL_SPLIT];
  assign run_high       = ctrl_q[`ART_CTL_RUN];
  assign low_irq_enable = ctrl_q[`ART_CTL_LO_IRQ];
  assign capt_mode      = ctrl_q[`ART_CTL_CAPT];

  // per-half tick
  // capture mode never counts the low half on the measured clock; the split high half still can
  assign lo_tick = sel_tick(clk_ctrl_q[`ART_CKC_LO_SYS], ctrl_q[`ART_CTL_XCLK] && !capt_mode,
                            tick12_q, tick8);
  assign hi_tick = sel_tick(clk_ctrl_q[`ART_CKC_HI_SYS], ctrl_q[`ART_CTL_XCLK],
                            tick12_q, tick8);

  // ----------------------------------------------------------------------
  // counter, reload and capture
  // ----------------------------------------------------------------------
  // software writes to a byte win over the count in the same cycle
  always @* begin
    count_low_d   = count_low_q;
    count_high_d  = count_high_q;
    reload_low_d  = reload_low_q;
    reload_high_d = reload_high_q;
    ovf_lo_ev     = 1'b0;
    ovf_hi_ev     = 1'b0;
    if (!split) begin
      // cascaded count, capture needs no run bit
      if ((run_high || capt_mode) && lo_tick) begin
        if ({count_high_q, count_low_q} == `ART_CNT_FULL) begin
          count_low_d  = reload_low_q;
          count_high_d = reload_high_q;
          ovf_hi_ev    = 1'b1;
        end else if (count_low_q == `ART_LO_FULL) begin
          count_low_d  = 8'h00;
          count_high_d = count_high_q + 8'h01;
        end else begin
          count_low_d  = count_low_q + 8'h01;
        end
        ovf_lo_ev = (count_low_q == `ART_LO_FULL);
      end
    end else begin
      if (lo_tick) begin
        if (count_low_q == `ART_LO_FULL) begin
          count_low_d = reload_low_q;
          ovf_lo_ev   = 1'b1;
        end else begin
          count_low_d = count_low_q + 8'h01;
        end
      end
      if (run_high && hi_tick) begin
        if (count_high_q == `ART_LO_FULL) begin
          count_high_d = reload_high_q;
          ovf_hi_ev    = 1'b1;
        end else begin
          count_high_d = count_high_q + 8'h01;
        end
      end
    end
    if (capt_ev) begin
      reload_low_d  = count_low_q;
      reload_high_d = count_high_q;
    end
    if (hit(`ART_OFS_CNT_LO, avs_address, do_wr)) begin
      count_low_d = avs_writedata[7:0];
    end
    if (hit(`ART_OFS_CNT_HI, avs_address, do_wr)) begin
      count_high_d = avs_writedata[7:0];
    end
    if (hit(`ART_OFS_RLD_LO, avs_address, do_wr)) begin
      reload_low_d = avs_writedata[7:0];
    end
    if (hit(`ART_OFS_RLD_HI, avs_address, do_wr)) begin
      reload_high_d = avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // control and flags
  // ----------------------------------------------------------------------
  // written bits land first, then hardware sets win over a software clear
  always @* begin
    ctrl_d = ctrl_q;
    if (hit(`ART_OFS_CTRL, avs_address, do_wr)) begin
      ctrl_d = avs_writedata[7:0] & `ART_CTL_WMASK;
    end
    if (ovf_hi_ev || capt_ev) begin
      ctrl_d[`ART_CTL_OVF_HI] = 1'b1;
    end
    if (ovf_lo_ev) begin
      ctrl_d[`ART_CTL_OVF_LO] = 1'b1;
    end
  end

  // sticky event status, cleared by reading it; a new event beats the clear
  always @* begin
    status_d = status_q;
    if (do_rd && avs_address == `ART_OFS_STATUS) begin
      status_d = `ART_RST_STAT;
    end
    status_d[`ART_ST_OVF_HI] = status_d[`ART_ST_OVF_HI] || ovf_hi_ev;
    status_d[`ART_ST_OVF_LO] = status_d[`ART_ST_OVF_LO] || ovf_lo_ev;
    status_d[`ART_ST_CAPT]   = status_d[`ART_ST_CAPT] || capt_ev;
  end

  // all software-visible register state
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q        <= `ART_RST_BYTE;
      count_low_q   <= `ART_RST_BYTE;
      count_high_q  <= `ART_RST_BYTE;
      reload_low_q  <= `ART_RST_BYTE;
      reload_high_q <= `ART_RST_BYTE;
      clk_ctrl_q    <= `ART_RST_BYTE;
      irq_en_q      <= `ART_RST_BYTE;
      status_q      <= `ART_RST_STAT;
      mask_q        <= `ART_RST_STAT;
    end else begin
      ctrl_q        <= ctrl_d;
      count_low_q   <= count_low_d;
      count_high_q  <= count_high_d;
      reload_low_q  <= reload_low_d;
      reload_high_q <= reload_high_d;
      status_q      <= status_d;
      if (hit(`ART_OFS_CLK_CTRL, avs_address, do_wr)) begin
        clk_ctrl_q <= avs_writedata[7:0];
      end
      if (hit(`ART_OFS_IRQ_EN, avs_address, do_wr)) begin
        irq_en_q <= avs_writedata[7:0];
      end
      if (hit(`ART_OFS_MASK, avs_address, do_wr)) begin
        mask_q <= avs_writedata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------------
  // shared line
  // level from the overflow flags or an unmasked sticky status bit, all
  // behind the timer enable; the low source needs the low enable too
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_en_q[`ART_IE_TIMER] &&
             (ctrl_q[`ART_CTL_OVF_HI] ||
              (low_irq_enable && ctrl_q[`ART_CTL_OVF_LO]) ||
              (status_q[`ART_ST_OVF_HI] && mask_q[`ART_ST_OVF_HI]) ||
              (status_q[`ART_ST_CAPT] && mask_q[`ART_ST_CAPT]) ||
              (low_irq_enable && status_q[`ART_ST_OVF_LO] &&
               mask_q[`ART_ST_OVF_LO]));
    end
  end

endmodule

// *** verilog/art_timer_map.vh ***
// art_timer_map.vh: register offsets, field positions, reset values and
// clock ratios for the auto-reload timer with capture.
// assumes a 32-bit avalon-mm slave with byte addresses, one word a register.
`ifndef ART_TIMER_MAP_VH
`define ART_TIMER_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ART_OFS_CTRL      6'h00
`define ART_OFS_CNT_LO    6'h04
`define ART_OFS_CNT_HI    6'h08
`define ART_OFS_RLD_LO    6'h0C
`define ART_OFS_RLD_HI    6'h10
`define ART_OFS_CLK_CTRL  6'h14
`define ART_OFS_IRQ_EN    6'h18
`define ART_OFS_STATUS    6'h1C
`define ART_OFS_MASK      6'h20

// ----------------------------------------------------------------------
// timer_ctrl_reg fields
// ----------------------------------------------------------------------
`define ART_CTL_OVF_HI    7
`define ART_CTL_OVF_LO    6
`define ART_CTL_LO_IRQ    5
`define ART_CTL_CAPT      4
`define ART_CTL_SPLIT     3
`define ART_CTL_RUN       2
`define ART_CTL_XCLK      0
`define ART_CTL_WMASK     8'hFD

// clock_ctrl_reg and irq_enable_reg fields
`define ART_CKC_HI_SYS    5
`define ART_CKC_LO_SYS    4
`define ART_IE_TIMER      5

// status and mask fields
`define ART_ST_OVF_HI     0
`define ART_ST_OVF_LO     1
`define ART_ST_CAPT       2

// ----------------------------------------------------------------------
// reset values and clock ratios
// ----------------------------------------------------------------------
`define ART_RST_BYTE      8'h00
`define ART_RST_STAT      3'h0
`define ART_DIV_SYS       4'hC
`define ART_DIV_EXT_HALF  2'h3
`define ART_LO_FULL       8'hFF
`define ART_CNT_FULL      16'hFFFF

`endif
